/* lpom_far_end.sv */
// Purpose: far-end stand-in driving received events, alarms and frames
// Assumes: outputs change by non-blocking assignment after a rising edge
// Notes: C2 goes stale (inverted) outside its valid pulse
`timescale 1ns/1ps
module lpom_far_end
  import lpom_pkg::*;
(
  input wire logic sys_clk,
  output logic [2:0] ev_pulse,
  output lpom_alarm_s path_alarm,
  output logic c2_valid,
  output logic [7:0] c2_byte,
  output logic tx_frame_start
);
  initial begin
    ev_pulse = 3'h0;
    path_alarm = '0;
    c2_valid = 1'b0;
    c2_byte = 8'h00;
    tx_frame_start = 1'b0;
  end

  // Bit 0 line far end, 1 path parity, 2 path far end
  task automatic ev(input int k);
    @(posedge sys_clk);
    ev_pulse <= 3'(1 << k);
    @(posedge sys_clk);
    ev_pulse <= 3'h0;
    #1;
  endtask

  // Pulse held high for n cycles counts n events
  task automatic burst(input int k, input int n);
    @(posedge sys_clk);
    ev_pulse <= 3'(1 << k);
    repeat (n) @(posedge sys_clk);
    ev_pulse <= 3'h0;
    #1;
  endtask

  task automatic alarm(input logic [2:0] a);
    @(posedge sys_clk);
    path_alarm <= a;
    @(posedge sys_clk);
    #1;
  endtask

  task automatic frame(input logic [7:0] c);
    @(posedge sys_clk);
    c2_valid <= 1'b1;
    c2_byte <= c;
    tx_frame_start <= 1'b1;
    @(posedge sys_clk);
    c2_valid <= 1'b0;
    c2_byte <= ~c;
    tx_frame_start <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
endmodule

/* lpom_params.svh */
// Purpose: constants of the line/path overhead monitor registers
// Assumes: byte-wide register port, 20 MHz sys_clk
// Notes: offsets are byte addresses on the register port
// Operation
// [RULE1] 20-bit line far-end count, three bytes
// [RULE2] Line count write latches, restarts accumulation
// [RULE3] Master address write latches every counter
// [RULE4] Remote defect bit puts 110 in K2
// [RULE5] Software writes zero to reserved bits
// [RULE6] Corruption bit inverts every B2 byte
// [RULE7] Path status shows live alarm states
// [RULE8] Parity and far-end events set flags
// [RULE9] Alarm toggles set change flags
// [RULE10] Label change sets label flag
// [RULE11] Reading flags clears them and interrupt
// [RULE12] Far-end flag enabled raises interrupt
// [RULE13] Parity flag enabled raises interrupt
// [RULE14] Defect and alarm changes raise interrupt
// [RULE15] Pointer loss change raises interrupt
// [RULE16] Label change raises interrupt when enabled
// [RULE17] Label updates after three identical frames
// [RULE18] Low byte of path parity count
// [RULE19] Path count write latches, keeps events
// [RULE20] Interrupt is OR of enabled flags
// [RULE21] Transmit controls apply at frame boundary
`ifndef LPOM_PARAMS_SVH
`define LPOM_PARAMS_SVH
`define LPOM_A_MASTER 8'h00
`define LPOM_A_LBIP_LO 8'h1a
`define LPOM_A_LFE_LO 8'h1d
`define LPOM_A_LFE_MID 8'h1e
`define LPOM_A_LFE_HI 8'h1f
`define LPOM_A_TXCTL 8'h20
`define LPOM_A_TXDIAG 8'h21
`define LPOM_A_PSTAT 8'h30
`define LPOM_A_PFLAG 8'h31
`define LPOM_A_PEN 8'h33
`define LPOM_A_LABEL 8'h37
`define LPOM_A_PBIP_LO 8'h38
`define LPOM_A_PFEBE_HI 8'h3b
`define LPOM_B_FAR 0
`define LPOM_B_PAR 1
`define LPOM_B_DEF 2
`define LPOM_B_AIS 3
`define LPOM_B_LOP 5
`define LPOM_B_LBL 7
`define LPOM_B_CTL 0
`define LPOM_FLAG_MASK 8'haf
`define LPOM_PSTAT_RW 8'h81
`define LPOM_K2_RDI 3'b110
`define LPOM_LBL_HITS 2'h2
`define LPOM_LATCH_NS 7000
`define LPOM_CLK_NS 50
`define LPOM_LATCH_CYC ((`LPOM_LATCH_NS) / (`LPOM_CLK_NS))
`define LPOM_ZERO8 8'h00
`define LPOM_LFE_MAX 20'hfffff
`define LPOM_PBE_MAX 16'hffff
`endif

/* lpom_pkg.sv */
// Purpose: types of the line/path overhead monitor registers
// Assumes: used with lpom_params.svh
// Notes: whole block state is one packed struct
package lpom_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } lpom_bus_s;

  typedef struct packed {
    logic pointer_loss_state;
    logic ais;
    logic line_remote_defect_insert;
  } lpom_alarm_s;

  typedef struct packed {
    logic [19:0] lfe_acc;
    logic [19:0] lfe_hold;
    logic [15:0] pbe_acc;
    logic [15:0] pbe_hold;
    logic [7:0] tx_ctl;
    logic [7:0] tx_diag;
    logic [7:0] pstat_rw;
    logic [7:0] flags;
    logic [7:0] enables;
    lpom_alarm_s alarm_d;
    logic [7:0] label;
    logic [7:0] cand;
    logic [1:0] hits;
    logic rdi_on;
    logic corrupt_on;
    logic [7:0] k2_out;
    logic [7:0] b2_out;
    logic [7:0] rdata;
    logic load_all;
  } lpom_state_s;
endpackage

/* lpom_regs.sv */
// Purpose: line/path overhead monitor register bank
// Assumes: event inputs are one-cycle pulses on sys_clk
// Notes: counters saturate rather than wrap
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`include "lpom_params.svh"
module lpom_regs
  import lpom_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire lpom_bus_s bus,
  output logic [7:0] bus_rdata,
  input wire logic line_far_end_err,
  input wire logic path_parity_err,
  input wire logic path_far_end_err,
  input wire lpom_alarm_s path_alarm,
  input wire logic c2_valid,
  input wire logic [7:0] c2_byte,
  input wire logic tx_frame_start,
  input wire logic [7:0] k2_in,
  input wire logic [7:0] b2_in,
  output logic [7:0] k2_out,
  output logic [7:0] b2_out,
  output logic load_meters,
  output logic irq
);

  lpom_state_s st_reg;
  lpom_state_s st_next;
  lpom_alarm_s alarm_chg;
  logic line_poll;
  logic path_poll;
  logic master_wr;
  logic flag_rd;
  logic label_set;
  logic [7:0] flag_set;

  // Line count poll: BIP and far-end addresses
  function automatic logic is_line_addr(input logic [7:0] a);
    is_line_addr = (a >= `LPOM_A_LBIP_LO) && (a <= `LPOM_A_LFE_HI);
  endfunction

  // Path count poll: BIP and far-end addresses
  function automatic logic is_path_addr(input logic [7:0] a);
    is_path_addr = (a >= `LPOM_A_PBIP_LO) && (a <= `LPOM_A_PFEBE_HI);
  endfunction

  function automatic logic [19:0] sat20(input logic [19:0] v, input logic inc);
    sat20 = (inc && v != `LPOM_LFE_MAX) ? v + 20'h1 : v;
  endfunction

  function automatic logic [15:0] sat16(input logic [15:0] v, input logic inc);
    sat16 = (inc && v != `LPOM_PBE_MAX) ? v + 16'h1 : v;
  endfunction

  assign master_wr = bus.wr && bus.addr == `LPOM_A_MASTER;
  assign line_poll = bus.wr && (is_line_addr(bus.addr) || master_wr);
  assign path_poll = bus.wr && (is_path_addr(bus.addr) || master_wr);
  assign flag_rd = bus.rd && bus.addr == `LPOM_A_PFLAG;
  assign alarm_chg = path_alarm ^ st_reg.alarm_d;
  assign label_set = c2_valid && c2_byte != st_reg.label
    && c2_byte == st_reg.cand && st_reg.hits == `LPOM_LBL_HITS;

  always_comb begin
    flag_set = `LPOM_ZERO8;
    flag_set[`LPOM_B_FAR] = path_far_end_err;
    flag_set[`LPOM_B_PAR] = path_parity_err;
    flag_set[`LPOM_B_DEF] = alarm_chg.line_remote_defect_insert;
    flag_set[`LPOM_B_AIS] = alarm_chg.ais;
    flag_set[`LPOM_B_LOP] = alarm_chg.pointer_loss_state;
    flag_set[`LPOM_B_LBL] = label_set;
  end

  always_comb begin
    st_next = st_reg;
    st_next.load_all = master_wr;
    st_next.rdata = `LPOM_ZERO8;
    st_next.alarm_d = path_alarm;

    // [RULE1] line far-end accumulation
    st_next.lfe_acc = sat20(st_reg.lfe_acc, line_far_end_err);
    // [RULE2] [RULE3] latch and restart
    if (line_poll) begin
      st_next.lfe_hold = st_reg.lfe_acc;
      st_next.lfe_acc = {19'h0, line_far_end_err};
    end

    // [RULE18] path parity accumulation
    st_next.pbe_acc = sat16(st_reg.pbe_acc, path_parity_err);
    // [RULE19] coincident event kept
    if (path_poll) begin
      st_next.pbe_hold = st_reg.pbe_acc;
      st_next.pbe_acc = {15'h0, path_parity_err};
    end

    // [RULE8] [RULE9] [RULE10] flag setting
    st_next.flags = st_reg.flags | flag_set;
    // [RULE11] read clears, new events win
    if (flag_rd) begin
      st_next.flags = flag_set;
    end

    // [RULE17] three-frame label filter
    if (c2_valid) begin
      if (c2_byte == st_reg.label) begin
        st_next.hits = 2'h0;
      end else if (c2_byte == st_reg.cand) begin
        if (label_set) begin
          st_next.label = c2_byte;
          st_next.hits = 2'h0;
        end else begin
          st_next.hits = st_reg.hits + 2'h1;
        end
      end else begin
        st_next.cand = c2_byte;
        st_next.hits = 2'h1;
      end
    end

    // [RULE5] TXCTL and enables stored as written; TXDIAG keeps bit 0, PSTAT keeps bits 7 and 0
    if (bus.wr) begin
      case (bus.addr)
        `LPOM_A_TXCTL: begin
          st_next.tx_ctl = bus.wdata;
        end
        `LPOM_A_TXDIAG: begin
          st_next.tx_diag = {7'h0, bus.wdata[`LPOM_B_CTL]};
        end
        `LPOM_A_PSTAT: begin
          st_next.pstat_rw = bus.wdata & `LPOM_PSTAT_RW;
        end
        `LPOM_A_PEN: begin
          st_next.enables = bus.wdata;
        end
        default: begin
        end
      endcase
    end

    if (bus.rd) begin
      case (bus.addr)
        `LPOM_A_LFE_LO: begin
          st_next.rdata = st_reg.lfe_hold[7:0];
        end
        `LPOM_A_LFE_MID: begin
          st_next.rdata = st_reg.lfe_hold[15:8];
        end
        `LPOM_A_LFE_HI: begin
          st_next.rdata = {4'h0, st_reg.lfe_hold[19:16]};
        end
        `LPOM_A_TXCTL: begin
          st_next.rdata = st_reg.tx_ctl;
        end
        `LPOM_A_TXDIAG: begin
          st_next.rdata = st_reg.tx_diag;
        end
        `LPOM_A_PSTAT: begin
          // [RULE7] live alarm states
          st_next.rdata = st_reg.pstat_rw;
          st_next.rdata[`LPOM_B_DEF] = path_alarm.line_remote_defect_insert;
          st_next.rdata[`LPOM_B_AIS] = path_alarm.ais;
          st_next.rdata[`LPOM_B_LOP] = path_alarm.pointer_loss_state;
        end
        `LPOM_A_PFLAG: begin
          st_next.rdata = st_reg.flags;
        end
        `LPOM_A_PEN: begin
          st_next.rdata = st_reg.enables;
        end
        `LPOM_A_LABEL: begin
          st_next.rdata = st_reg.label;
        end
        `LPOM_A_PBIP_LO: begin
          st_next.rdata = st_reg.pbe_hold[7:0];
        end
        default: begin
          st_next.rdata = `LPOM_ZERO8;
        end
      endcase
    end

    // [RULE21] controls sampled only at frame start
    if (tx_frame_start) begin
      st_next.rdi_on = st_reg.tx_ctl[`LPOM_B_CTL];
      st_next.corrupt_on = st_reg.tx_diag[`LPOM_B_CTL];
    end
    // [RULE4] remote defect code in K2 bits 6-8
    st_next.k2_out = k2_in;
    if (st_reg.rdi_on) begin
      st_next.k2_out = {k2_in[7:3], `LPOM_K2_RDI};
    end
    // [RULE6] B2 inversion
    st_next.b2_out = st_reg.corrupt_on ? ~b2_in : b2_in;
  end

  // Alarm history resets to clear so no change flags fire at start
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign bus_rdata = st_reg.rdata;
  assign k2_out = st_reg.k2_out;
  assign b2_out = st_reg.b2_out;
  assign load_meters = st_reg.load_all;
  // [RULE12] [RULE13] [RULE14] [RULE15] [RULE16] [RULE20] interrupt
  assign irq = |(st_reg.flags & st_reg.enables & `LPOM_FLAG_MASK);

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  sequence s_line_poll;
    line_poll;
  endsequence

  sequence s_lat_done(logic [19:0] v);
    st_reg.lfe_hold == v;
  endsequence

  property p_line_latch;
    logic [19:0] v;
    (s_line_poll, v = st_reg.lfe_acc) |=> s_lat_done(v);
  endproperty

  a_line_count_latch: assert property (p_line_latch) // [RULE2]
    else $error("line count not latched");

  a_line_acc_restart: assert property (line_poll |=> st_reg.lfe_acc <= 20'h1) // [RULE2]
    else $error("line accumulator not restarted");

  // Both units latch on the one master write
  a_master_latch_all: assert property ( // [RULE3]
    master_wr |=> load_meters
      && st_reg.lfe_hold == $past(st_reg.lfe_acc)
      && st_reg.pbe_hold == $past(st_reg.pbe_acc))
    else $error("master write did not pulse load");

  a_path_keep_event: assert property (path_poll && path_parity_err |=> st_reg.pbe_acc == 16'h1) // [RULE19]
    else $error("coincident path event lost");

  a_latch_in_time: assert property (path_poll |=> st_reg.pbe_hold == $past(st_reg.pbe_acc)) // [RULE19]
    else $error("latch bound below one cycle");

  a_k2_defect_code: assert property (st_reg.rdi_on |=> k2_out[2:0] == `LPOM_K2_RDI) // [RULE4]
    else $error("K2 remote defect code missing");

  a_b2_inverted: assert property (st_reg.corrupt_on |=> b2_out == ~$past(b2_in)) // [RULE6]
    else $error("B2 not inverted");

  a_ctl_at_frame: assert property (!tx_frame_start |=> st_reg.rdi_on == $past(st_reg.rdi_on)) // [RULE21]
    else $error("defect insertion changed mid frame");

  a_status_live: assert property ( // [RULE7]
    bus.rd && bus.addr == `LPOM_A_PSTAT |=> bus_rdata[`LPOM_B_LOP] == $past(path_alarm.pointer_loss_state))
    else $error("pointer loss state not live");

  a_parity_flag_set: assert property (path_parity_err |=> st_reg.flags[`LPOM_B_PAR]) // [RULE8]
    else $error("parity flag not set");

  a_alarm_toggle_flag: assert property ($changed(path_alarm.ais) |-> ##1 st_reg.flags[`LPOM_B_AIS]) // [RULE9]
    else $error("alarm change flag not set");

  a_flag_read_clear: assert property ( // [RULE11]
    flag_rd && flag_set == `LPOM_ZERO8 |=> st_reg.flags == `LPOM_ZERO8 && !irq)
    else $error("flags not cleared by read");

  // Any enabled event raises the request next cycle; a write may drop the enable
  a_irq_equation: assert property ( // [RULE20]
    (flag_set & st_reg.enables & `LPOM_FLAG_MASK) != `LPOM_ZERO8 && !bus.wr |=> irq)
    else $error("interrupt does not follow flags");

  a_far_end_irq: assert property (path_far_end_err && st_reg.enables[`LPOM_B_FAR] && !bus.wr |=> irq) // [RULE12]
    else $error("far-end interrupt missing");

  a_label_three: assert property ( // [RULE17]
    st_reg.label != $past(st_reg.label) |-> $past(st_reg.hits) == `LPOM_LBL_HITS)
    else $error("label changed too early");

  a_label_flag: assert property (label_set |=> st_reg.flags[`LPOM_B_LBL]) // [RULE10]
    else $error("label change flag not set");
endmodule

/* tb_line_path_overhead_monitor_regs.sv */
// Purpose: self-checking bench for the overhead monitor register bank
// Assumes: latch delay of one cycle, bus master on sys_clk rising edge
// Notes: K2 and B2 transmit inputs change once mid-test
`timescale 1ns/1ps
`include "lpom_params.svh"
module tb_line_path_overhead_monitor_regs;
  import lpom_pkg::*;
  logic sys_clk, resetn, c2_valid, tx_frame_start, load_meters, irq;
  lpom_bus_s bus;
  lpom_alarm_s path_alarm;
  logic [2:0] ev_pulse;
  logic [7:0] bus_rdata, c2_byte, k2_out, b2_out;
  logic [7:0] k2_in, b2_in;
  int fail_count, n_compared;

  lpom_far_end u_far (.sys_clk(sys_clk), .ev_pulse(ev_pulse), .path_alarm(path_alarm),
    .c2_valid(c2_valid), .c2_byte(c2_byte), .tx_frame_start(tx_frame_start));

  lpom_regs u_dut (.sys_clk(sys_clk), .resetn(resetn), .bus(bus), .bus_rdata(bus_rdata),
    .line_far_end_err(ev_pulse[0]), .path_parity_err(ev_pulse[1]), .path_far_end_err(ev_pulse[2]),
    .path_alarm(path_alarm), .c2_valid(c2_valid), .c2_byte(c2_byte), .tx_frame_start(tx_frame_start),
    .k2_in(k2_in), .b2_in(b2_in), .k2_out(k2_out), .b2_out(b2_out), .load_meters(load_meters), .irq(irq));

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus.wr <= 1'b1;
    bus.addr <= a;
    bus.wdata <= d;
    @(posedge sys_clk);
    bus.wr <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    bus.rd <= 1'b1;
    bus.addr <= a;
    @(posedge sys_clk);
    bus.rd <= 1'b0;
    #1;
    check(name, bus_rdata, exp);
  endtask

  // One cycle of slack for a registered interrupt
  task automatic irq_is(input logic e);
    @(posedge sys_clk);
    #1;
    check("irq", {7'h00, irq}, {7'h00, e});
  endtask

  task automatic t_reset();
    rd_chk("enables", `LPOM_A_PEN, 8'h00);
    rd_chk("unmapped", 8'h50, 8'h00);
    rd_chk("label", `LPOM_A_LABEL, 8'h00);
    irq_is(1'b0);
  endtask

  task automatic t_line();
    repeat (5) u_far.ev(0);
    wr(`LPOM_A_LFE_MID, 8'h00);
    rd_chk("lfe lo", `LPOM_A_LFE_LO, 8'h05);
    rd_chk("lfe mid", `LPOM_A_LFE_MID, 8'h00);
    rd_chk("lfe hi", `LPOM_A_LFE_HI, 8'h00);
    u_far.ev(0);
    wr(`LPOM_A_LBIP_LO, 8'h00);
    rd_chk("lfe lo", `LPOM_A_LFE_LO, 8'h01);
    wr(`LPOM_A_LFE_HI, 8'h00);
    rd_chk("lfe lo", `LPOM_A_LFE_LO, 8'h00);
    // 300 events carry into the middle byte
    u_far.burst(0, 300);
    wr(`LPOM_A_LFE_LO, 8'h00);
    rd_chk("lfe lo", `LPOM_A_LFE_LO, 8'h2c);
    rd_chk("lfe mid", `LPOM_A_LFE_MID, 8'h01);
    rd_chk("lfe hi", `LPOM_A_LFE_HI, 8'h00);
    repeat (3) u_far.ev(0);
    repeat (2) u_far.ev(1);
    wr(`LPOM_A_MASTER, 8'h00);
    check("load", {7'h00, load_meters}, 8'h01);
    rd_chk("lfe lo", `LPOM_A_LFE_LO, 8'h03);
    rd_chk("pbe lo", `LPOM_A_PBIP_LO, 8'h02);
    u_far.ev(1);
    wr(`LPOM_A_PFEBE_HI, 8'h00);
    rd_chk("pbe lo", `LPOM_A_PBIP_LO, 8'h01);
  endtask

  task automatic t_tx();
    wr(`LPOM_A_TXCTL, 8'h01);
    repeat (3) @(posedge sys_clk);
    #1;
    check("k2 hold", k2_out, k2_in);
    @(posedge sys_clk);
    k2_in <= 8'h57;
    b2_in <= 8'hc5;
    u_far.frame(8'h00);
    check("k2 rdi", k2_out, {k2_in[7:3], 3'b110});
    check("b2 clean", b2_out, b2_in);
    wr(`LPOM_A_TXDIAG, 8'h01);
    u_far.frame(8'h00);
    check("b2 inv", b2_out, ~b2_in);
    wr(`LPOM_A_TXCTL, 8'h00);
    check("k2 rdi held", k2_out, {k2_in[7:3], 3'b110});
    wr(`LPOM_A_TXDIAG, 8'h00);
    u_far.frame(8'h00);
    check("k2 off", k2_out, k2_in);
    check("b2 off", b2_out, b2_in);
  endtask

  task automatic t_flags();
    logic [7:0] fb [5] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h20};
    rd_chk("flags", `LPOM_A_PFLAG, 8'h02);
    wr(`LPOM_A_PEN, 8'haf);
    rd_chk("enables", `LPOM_A_PEN, 8'haf);
    for (int k = 0; k < 5; k++) begin
      if (k < 2) begin
        u_far.ev(2 - k);
      end else begin
        u_far.alarm(3'(1 << (k - 2)));
        rd_chk("live", `LPOM_A_PSTAT, fb[k]);
      end
      irq_is(1'b1);
      rd_chk("flags", `LPOM_A_PFLAG, fb[k]);
      irq_is(1'b0);
      if (k >= 2) begin
        u_far.alarm(3'h0);
        rd_chk("flags", `LPOM_A_PFLAG, fb[k]);
      end
    end
    // Only far-end enabled: a parity event must stay silent
    wr(`LPOM_A_PEN, 8'h01);
    u_far.ev(1);
    irq_is(1'b0);
    rd_chk("flags", `LPOM_A_PFLAG, 8'h02);
    wr(`LPOM_A_PEN, 8'h00);
    u_far.ev(2);
    irq_is(1'b0);
    rd_chk("flags", `LPOM_A_PFLAG, 8'h01);
  endtask

  task automatic t_label();
    wr(`LPOM_A_PEN, 8'h80);
    u_far.frame(8'h13);
    u_far.frame(8'h13);
    rd_chk("label", `LPOM_A_LABEL, 8'h00);
    irq_is(1'b0);
    u_far.frame(8'h13);
    irq_is(1'b1);
    rd_chk("label", `LPOM_A_LABEL, 8'h13);
    rd_chk("flags", `LPOM_A_PFLAG, 8'h80);
    u_far.frame(8'h22);
    u_far.frame(8'h22);
    u_far.frame(8'h44);
    u_far.frame(8'h22);
    rd_chk("label", `LPOM_A_LABEL, 8'h13);
    rd_chk("flags", `LPOM_A_PFLAG, 8'h00);
  endtask

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  initial begin
    resetn = 1'b0;
    bus = '0;
    k2_in = 8'ha8;
    b2_in = 8'h3c;
    fail_count = 0;
    n_compared = 0;
    repeat (16) @(posedge sys_clk);
    resetn <= 1'b1;
    t_reset();
    t_line();
    t_tx();
    t_flags();
    t_label();
    final_report();
  end

  // Whole run is well under a thousand cycles
  initial begin
    #(5000 * 50);
    fail_count++;
    final_report();
  end
endmodule
